// >>> bsp_pkg.sv
// bsp_pkg: shared constants and types for the boundary-scan port that
// borrows five general-purpose pins while the test-select pin is low.
// assumes: included first in the compile order; nothing is imported.
`default_nettype none

package bsp_pkg;

	// ************************************************************
	// pin map and sizes
	// ************************************************************
	localparam int BSP_NUM_PINS = 5;
	localparam int BSP_PIN_TCK = 0;
	localparam int BSP_PIN_TMS = 1;
	localparam int BSP_PIN_TDI = 2;
	localparam int BSP_PIN_TDO = 3;
	localparam int BSP_PIN_TRST = 4;
	localparam int BSP_IR_LEN = 4;
	localparam int BSP_ID_LEN = 32;

	// ************************************************************
	// instruction codes; bypass must be all ones
	// ************************************************************
	localparam logic [3:0] BSP_OP_EXTEST = 4'h0;
	localparam logic [3:0] BSP_OP_SAMPLE = 4'h1;
	localparam logic [3:0] BSP_OP_PRELOAD = 4'h2;
	localparam logic [3:0] BSP_OP_IDCODE = 4'h3;
	localparam logic [3:0] BSP_OP_HIGHZ = 4'h4;
	localparam logic [3:0] BSP_OP_CLAMP = 4'h5;
	localparam logic [3:0] BSP_OP_BYPASS = 4'hf;
	localparam logic [3:0] BSP_IR_CAPTURE = 4'h1;
	localparam logic [3:0] BSP_IR_RESET = BSP_OP_IDCODE;

	// ************************************************************
	// synchroniser vector layout and reset values
	// ************************************************************
	localparam int BSP_SYNC_W = 7;
	localparam int BSP_SYNC_TSEL = 5;
	localparam int BSP_SYNC_TAKEN = 6;
	localparam logic [6:0] BSP_SYNC_RESET = 7'h20;
	localparam logic [4:0] BSP_GPIO_RESET = 5'h00;

	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [3:0] {
		BSP_TLR = 4'h0,
		BSP_RTI = 4'h1,
		BSP_SEL_DR = 4'h2,
		BSP_CAP_DR = 4'h3,
		BSP_SHIFT_DR = 4'h4,
		BSP_EXIT1_DR = 4'h5,
		BSP_PAUSE_DR = 4'h6,
		BSP_EXIT2_DR = 4'h7,
		BSP_UPD_DR = 4'h8,
		BSP_SEL_IR = 4'h9,
		BSP_CAP_IR = 4'ha,
		BSP_SHIFT_IR = 4'hb,
		BSP_EXIT1_IR = 4'hc,
		BSP_PAUSE_IR = 4'hd,
		BSP_EXIT2_IR = 4'he,
		BSP_UPD_IR = 4'hf
	} bsp_tap_state_t;

	typedef struct packed {
		logic extest;
		logic sample;
		logic preload;
		logic idcode;
		logic highz;
		logic clamp;
		logic bypass;
	} bsp_instr_t;

	typedef struct packed {
		logic [4:0] level;
		logic [4:0] oe;
	} bsp_gpio_t;

endpackage : bsp_pkg

`default_nettype wire

// >>> bsp_tap_fsm.sv
// bsp_tap_fsm: the sixteen-state test access port controller.
// assumes: tck_i is the test clock; trst_n_i is an asynchronous reset
// already combined from the test reset pin and the test-select pin.
`default_nettype none

module bsp_tap_fsm (
	input wire logic tck_i,
	input wire logic trst_n_i,
	input wire logic tms_i,
	output bsp_pkg::bsp_tap_state_t state_o
);

	// ************************************************************
	// next state
	// ************************************************************
	function automatic bsp_pkg::bsp_tap_state_t bsp_next(
		input bsp_pkg::bsp_tap_state_t s, input logic tms);
		case (s)
			bsp_pkg::BSP_TLR: bsp_next = tms ? bsp_pkg::BSP_TLR
				: bsp_pkg::BSP_RTI;
			bsp_pkg::BSP_RTI: bsp_next = tms ? bsp_pkg::BSP_SEL_DR
				: bsp_pkg::BSP_RTI;
			bsp_pkg::BSP_SEL_DR: bsp_next = tms ? bsp_pkg::BSP_SEL_IR
				: bsp_pkg::BSP_CAP_DR;
			bsp_pkg::BSP_CAP_DR: bsp_next = tms ? bsp_pkg::BSP_EXIT1_DR
				: bsp_pkg::BSP_SHIFT_DR;
			bsp_pkg::BSP_SHIFT_DR: bsp_next = tms ? bsp_pkg::BSP_EXIT1_DR
				: bsp_pkg::BSP_SHIFT_DR;
			bsp_pkg::BSP_EXIT1_DR: bsp_next = tms ? bsp_pkg::BSP_UPD_DR
				: bsp_pkg::BSP_PAUSE_DR;
			bsp_pkg::BSP_PAUSE_DR: bsp_next = tms ? bsp_pkg::BSP_EXIT2_DR
				: bsp_pkg::BSP_PAUSE_DR;
			bsp_pkg::BSP_EXIT2_DR: bsp_next = tms ? bsp_pkg::BSP_UPD_DR
				: bsp_pkg::BSP_SHIFT_DR;
			bsp_pkg::BSP_UPD_DR: bsp_next = tms ? bsp_pkg::BSP_SEL_DR
				: bsp_pkg::BSP_RTI;
			bsp_pkg::BSP_SEL_IR: bsp_next = tms ? bsp_pkg::BSP_TLR
				: bsp_pkg::BSP_CAP_IR;
			bsp_pkg::BSP_CAP_IR: bsp_next = tms ? bsp_pkg::BSP_EXIT1_IR
				: bsp_pkg::BSP_SHIFT_IR;
			bsp_pkg::BSP_SHIFT_IR: bsp_next = tms ? bsp_pkg::BSP_EXIT1_IR
				: bsp_pkg::BSP_SHIFT_IR;
			bsp_pkg::BSP_EXIT1_IR: bsp_next = tms ? bsp_pkg::BSP_UPD_IR
				: bsp_pkg::BSP_PAUSE_IR;
			bsp_pkg::BSP_PAUSE_IR: bsp_next = tms ? bsp_pkg::BSP_EXIT2_IR
				: bsp_pkg::BSP_PAUSE_IR;
			bsp_pkg::BSP_EXIT2_IR: bsp_next = tms ? bsp_pkg::BSP_UPD_IR
				: bsp_pkg::BSP_SHIFT_IR;
			bsp_pkg::BSP_UPD_IR: bsp_next = tms ? bsp_pkg::BSP_SEL_DR
				: bsp_pkg::BSP_RTI;
			default: bsp_next = bsp_pkg::BSP_TLR;
		endcase
	endfunction : bsp_next

	bsp_pkg::bsp_tap_state_t state_reg;

	// ************************************************************
	// state register
	// ************************************************************
	// reset works without a running test clock
	always_ff @(posedge tck_i or negedge trst_n_i) begin
		if (!trst_n_i) begin
			state_reg <= bsp_pkg::BSP_TLR;
		end else begin
			state_reg <= bsp_next(state_reg, tms_i);
		end
	end

	assign state_o = state_reg;

	// ************************************************************
	// checks
	// ************************************************************
	a_trst_forces_tlr: assert property (@(posedge tck_i)
		!trst_n_i |-> state_reg == bsp_pkg::BSP_TLR)
		else $error("test reset did not hold controller in reset state");

	a_tms_five_high: assert property (@(posedge tck_i)
		disable iff (!trst_n_i)
		tms_i [*5] |=> state_reg == bsp_pkg::BSP_TLR)
		else $error("five high mode-select bits did not reach reset state");

endmodule : bsp_tap_fsm

`default_nettype wire

// >>> bsp_pin_share_tap.sv
// bsp_pin_share_tap: boundary-scan port sharing five GPIO pins, with the
// pin multiplexer, the instruction and data registers and the halt level.
// assumes: gpio pins are split into level/enable outputs and an input by
// the pad ring; tck_i is the pad buffer of GPIO[0] routed as a clock.
// Function
// - select low: pins to scan, device halted
// - pins 0..4 are tck, tms, tdi, tdo, trst
// - select high: plain GPIO, normal operation
// - standard port with the seven listed instructions
// - identification instruction shifts a fixed word
`default_nettype none

module bsp_pin_share_tap #(
	parameter int BSR_LEN = 8,
	// arbitrary neutral value; bit 0 must stay one
	parameter logic [31:0] IDCODE_VALUE = 32'h0000_1001
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic tck_i,
	input wire logic test_access_select_n_i,
	input wire logic [4:0] gpio_pad_i,
	output bsp_pkg::bsp_gpio_t gpio_pad_o,
	input wire bsp_pkg::bsp_gpio_t core_gpio_i,
	output logic [4:0] gpio_din_o,
	output logic core_halt_o,
	input wire logic [BSR_LEN-1:0] bs_pad_in_i,
	input wire logic [BSR_LEN-1:0] core_pad_out_i,
	input wire logic [BSR_LEN-1:0] core_pad_oe_i,
	output logic [BSR_LEN-1:0] bs_pad_out_o,
	output logic [BSR_LEN-1:0] bs_pad_oe_o
);

	// ************************************************************
	// instruction decode
	// ************************************************************
	// unknown codes fall back to bypass, as the standard asks
	function automatic bsp_pkg::bsp_instr_t bsp_decode(input logic [3:0] ir);
		bsp_decode = '0;
		case (ir)
			bsp_pkg::BSP_OP_EXTEST: bsp_decode.extest = 1'b1;
			bsp_pkg::BSP_OP_SAMPLE: bsp_decode.sample = 1'b1;
			bsp_pkg::BSP_OP_PRELOAD: bsp_decode.preload = 1'b1;
			bsp_pkg::BSP_OP_IDCODE: bsp_decode.idcode = 1'b1;
			bsp_pkg::BSP_OP_HIGHZ: bsp_decode.highz = 1'b1;
			bsp_pkg::BSP_OP_CLAMP: bsp_decode.clamp = 1'b1;
			default: bsp_decode.bypass = 1'b1;
		endcase
	endfunction : bsp_decode

	// ************************************************************
	// system clock side: synchronisers
	// ************************************************************
	logic [6:0] sync1_reg;
	logic [6:0] sync2_reg;
	logic [6:0] sync3_reg;
	logic [6:0] filt_reg;
	logic [6:0] filt_next;
	logic [6:0] sync_raw;
	logic test_mode;
	logic taken_tck_reg;

	assign sync_raw = {taken_tck_reg, test_access_select_n_i, gpio_pad_i};

	// three stages; a bit moves only once stages two and three agree
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			sync1_reg <= bsp_pkg::BSP_SYNC_RESET;
			sync2_reg <= bsp_pkg::BSP_SYNC_RESET;
			sync3_reg <= bsp_pkg::BSP_SYNC_RESET;
		end else begin
			sync1_reg <= sync_raw;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	always_comb begin
		filt_next = (sync2_reg & ~(sync2_reg ^ sync3_reg))
			| (filt_reg & (sync2_reg ^ sync3_reg));
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			filt_reg <= bsp_pkg::BSP_SYNC_RESET;
		end else begin
			filt_reg <= filt_next;
		end
	end

	assign test_mode = ~filt_reg[bsp_pkg::BSP_SYNC_TSEL];
	assign gpio_din_o = filt_reg[4:0];
	// halt also covers scan owning pads (extest, clamp or highz), a level that the test reset clears as soon as select rises
	assign core_halt_o = test_mode
		| filt_reg[bsp_pkg::BSP_SYNC_TAKEN];

	// ************************************************************
	// test access port state
	// ************************************************************
	logic tap_rst_n;
	bsp_pkg::bsp_tap_state_t tap_state;

	// outside test mode the scan logic is held in reset
	assign tap_rst_n = ~test_access_select_n_i
		& gpio_pad_i[bsp_pkg::BSP_PIN_TRST];

	bsp_tap_fsm u_fsm (
		.tck_i(tck_i),
		.trst_n_i(tap_rst_n),
		.tms_i(gpio_pad_i[bsp_pkg::BSP_PIN_TMS]),
		.state_o(tap_state)
	);

	// ************************************************************
	// instruction register
	// ************************************************************
	logic [3:0] ir_shift_reg;
	logic [3:0] ir_reg;
	logic tdi;
	bsp_pkg::bsp_instr_t instr;

	assign tdi = gpio_pad_i[bsp_pkg::BSP_PIN_TDI];
	assign instr = bsp_decode(ir_reg);

	always_ff @(posedge tck_i or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			ir_shift_reg <= bsp_pkg::BSP_IR_CAPTURE;
		end else if (tap_state == bsp_pkg::BSP_CAP_IR) begin
			ir_shift_reg <= bsp_pkg::BSP_IR_CAPTURE;
		end else if (tap_state == bsp_pkg::BSP_SHIFT_IR) begin
			ir_shift_reg <= {tdi, ir_shift_reg[3:1]};
		end
	end

	// identification is the instruction after every reset
	always_ff @(negedge tck_i or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			ir_reg <= bsp_pkg::BSP_IR_RESET;
		end else if (tap_state == bsp_pkg::BSP_TLR) begin
			ir_reg <= bsp_pkg::BSP_IR_RESET;
		end else if (tap_state == bsp_pkg::BSP_UPD_IR) begin
			ir_reg <= ir_shift_reg;
		end
	end

	// ************************************************************
	// data registers
	// ************************************************************
	logic bypass_reg;
	logic [31:0] id_shift_reg;
	logic [BSR_LEN-1:0] bsr_shift_reg;
	logic [BSR_LEN-1:0] bsr_upd_reg;
	logic cap_dr;
	logic shift_dr;

	assign cap_dr = tap_state == bsp_pkg::BSP_CAP_DR;
	assign shift_dr = tap_state == bsp_pkg::BSP_SHIFT_DR;

	// one-bit bypass path, captures zero
	always_ff @(posedge tck_i or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			bypass_reg <= 1'b0;
		end else if (cap_dr) begin
			bypass_reg <= 1'b0;
		end else if (shift_dr) begin
			bypass_reg <= tdi;
		end
	end

	always_ff @(posedge tck_i or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			id_shift_reg <= 32'h0000_0000;
		end else if (cap_dr && instr.idcode) begin
			id_shift_reg <= IDCODE_VALUE;
		end else if (shift_dr && instr.idcode) begin
			id_shift_reg <= {tdi, id_shift_reg[31:1]};
		end
	end

	// sample, preload and extest all capture the pad levels
	always_ff @(posedge tck_i or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			bsr_shift_reg <= '0;
		end else if (cap_dr && (instr.sample | instr.preload
				| instr.extest)) begin
			bsr_shift_reg <= bs_pad_in_i;
		end else if (shift_dr && (instr.sample | instr.preload
				| instr.extest)) begin
			bsr_shift_reg <= {tdi, bsr_shift_reg[BSR_LEN-1:1]};
		end
	end

	// update stage changes on the falling edge so pads never ripple
	always_ff @(negedge tck_i or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			bsr_upd_reg <= '0;
		end else if (tap_state == bsp_pkg::BSP_UPD_DR
				&& (instr.sample | instr.preload | instr.extest)) begin
			bsr_upd_reg <= bsr_shift_reg;
		end
	end

	// ************************************************************
	// boundary pads and serial output
	// ************************************************************
	logic drive_bsr;
	logic tdo_reg;
	logic tdo_en_reg;
	logic tdo_next;

	// clamp holds preloaded levels while the path is bypass
	assign drive_bsr = instr.extest | instr.clamp;
	assign bs_pad_out_o = drive_bsr ? bsr_upd_reg : core_pad_out_i;
	assign bs_pad_oe_o = instr.highz ? '0
		: (drive_bsr ? '1 : core_pad_oe_i);

	always_comb begin
		tdo_next = bypass_reg;
		if (tap_state == bsp_pkg::BSP_SHIFT_IR) begin
			tdo_next = ir_shift_reg[0];
		end else if (instr.idcode) begin
			tdo_next = id_shift_reg[0];
		end else if (instr.sample | instr.preload | instr.extest) begin
			tdo_next = bsr_shift_reg[0];
		end
	end

	// serial out changes on the falling edge, enabled only in shifts
	always_ff @(negedge tck_i or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			tdo_reg <= 1'b0;
			tdo_en_reg <= 1'b0;
		end else begin
			tdo_reg <= tdo_next;
			tdo_en_reg <= shift_dr
				| (tap_state == bsp_pkg::BSP_SHIFT_IR);
		end
	end

	// level that crosses to the system clock through the synchroniser
	always_ff @(posedge tck_i or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			taken_tck_reg <= 1'b0;
		end else begin
			taken_tck_reg <= instr.extest | instr.clamp | instr.highz;
		end
	end

	// ************************************************************
	// pin multiplexer
	// ************************************************************
	// only the serial output is driven in test mode; other pins listen
	always_comb begin
		if (test_mode) begin
			gpio_pad_o.level = bsp_pkg::BSP_GPIO_RESET;
			gpio_pad_o.oe = bsp_pkg::BSP_GPIO_RESET;
			gpio_pad_o.level[bsp_pkg::BSP_PIN_TDO] = tdo_reg;
			gpio_pad_o.oe[bsp_pkg::BSP_PIN_TDO] = tdo_en_reg;
		end else begin
			gpio_pad_o = core_gpio_i;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	a_select_low_halts: assert property (@(posedge mclk_i)
		disable iff (!rst_n_i)
		(!test_access_select_n_i) [*4] |=> test_mode && core_halt_o)
		else $error("select held low but device not in test mode");

	a_select_high_runs: assert property (@(posedge mclk_i)
		disable iff (!rst_n_i)
		test_access_select_n_i [*4] |=> !test_mode)
		else $error("select held high but pins still in test mode");

	a_pin_map_test: assert property (@(posedge mclk_i)
		disable iff (!rst_n_i)
		test_mode |-> gpio_pad_o.oe[2:0] == 3'h0
			&& gpio_pad_o.level[3] == tdo_reg
			&& gpio_pad_o.oe[3] == tdo_en_reg && !gpio_pad_o.oe[4])
		else $error("shared pins not mapped to scan functions");

	a_pin_map_gpio: assert property (@(posedge mclk_i)
		disable iff (!rst_n_i)
		!test_mode |-> gpio_pad_o == core_gpio_i)
		else $error("shared pins not passing core gpio");

	a_bypass_capture: assert property (@(posedge tck_i)
		disable iff (!tap_rst_n)
		cap_dr && instr.bypass |=> bypass_reg == 1'b0)
		else $error("bypass cell did not capture zero");

	a_idcode_word: assert property (@(posedge tck_i)
		disable iff (!tap_rst_n)
		cap_dr && instr.idcode |=> id_shift_reg == IDCODE_VALUE)
		else $error("identification word not captured");

	a_highz_pads: assert property (@(posedge tck_i)
		disable iff (!tap_rst_n)
		instr.highz |-> bs_pad_oe_o == '0)
		else $error("pads still enabled under high impedance");

endmodule : bsp_pin_share_tap

`default_nettype wire

// >>> bsp_jtag_host.sv
// bsp_jtag_host: behavioural board test controller on the shared pins.
// assumes: tdo_i is the resolved tdo pin level; mclk_i is the device clock.
`default_nettype none

module bsp_jtag_host (
	input wire logic mclk_i,
	input wire logic tdo_i,
	output logic tck_o,
	output logic tms_o,
	output logic tdi_o,
	output logic trst_n_o,
	output logic sel_n_o,
	output logic mr_n_o
);
	timeunit 1ns;
	timeprecision 100ps;

	// tck idles low: it only runs inside a frame
	initial begin
		tck_o = 1'b0;
		tms_o = 1'b1;
		tdi_o = 1'b0;
		trst_n_o = 1'b1;
		sel_n_o = 1'b1;
		mr_n_o = 1'b1;
	end

	// ************************************************************
	// test clock frames
	// ************************************************************
	// one 15 ns test clock; pins move only after the falling edge
	task automatic clk(input logic ms, input logic di, output logic dq);
		tms_o = ms;
		tdi_o = di;
		#7.5;
		dq = tdo_i;
		tck_o = 1'b1;
		#7.5;
		tck_o = 1'b0;
	endtask : clk

	// five ones reach reset from any state, then park in idle
	task automatic reset_tap();
		logic b;
		repeat (5) clk(1'b1, 1'b0, b);
		clk(1'b0, 1'b0, b);
	endtask : reset_tap

	// from idle to the shift state of the chosen register
	task automatic enter_shift(input logic ir);
		logic b;
		clk(1'b1, 1'b0, b);
		if (ir)
			clk(1'b1, 1'b0, b);
		clk(1'b0, 1'b0, b);
		clk(1'b0, 1'b0, b);
	endtask : enter_shift

	// shift lsb first, leave through update back to idle
	task automatic shift_out(input int n, input logic [31:0] din,
		output logic [31:0] dout);
		logic b;
		dout = 32'h0000_0000;
		for (int i = 0; i < n; i++) begin
			clk(i == n - 1, din[i], b);
			dout[i] = b;
		end
		clk(1'b1, 1'b0, b);
		clk(1'b0, 1'b0, b);
	endtask : shift_out

	task automatic set_trst(input logic v);
		trst_n_o = v;
	endtask : set_trst

	// ************************************************************
	// select and master reset, moved on the device clock
	// ************************************************************
	task automatic enter_test();
		@(posedge mclk_i);
		sel_n_o <= 1'b0;
	endtask : enter_test

	// master reset pulse so the device restarts from a clean state
	task automatic leave_test();
		@(posedge mclk_i);
		sel_n_o <= 1'b1;
		mr_n_o <= 1'b0;
		repeat (2) @(posedge mclk_i);
		mr_n_o <= 1'b1;
	endtask : leave_test
endmodule : bsp_jtag_host

`default_nettype wire

// >>> bsp_pin_share_tap_bench.sv
// bsp_pin_share_tap_bench: self-checking bench for the shared scan port.
// assumes: bsp_pkg, the design and bsp_jtag_host are compiled before it.
`default_nettype none

module bsp_pin_share_tap_bench;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int BSR = 8;
	localparam logic [31:0] ID_WORD = 32'h0a5c_3001; // arbitrary, bit 0 set
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [4:0] ext_lvl;
	logic [7:0] bs_in;
	logic [7:0] core_out;
	logic [7:0] core_oe;
	bsp_pkg::bsp_gpio_t core_gpio;
	bsp_pkg::bsp_gpio_t gpio_out;
	logic [4:0] pad, drv, gpio_din;
	logic halt;
	logic [7:0] bs_out, bs_oe;
	logic h_tck, h_tms, h_tdi, h_trst_n, h_sel_n, h_mr_n;
	logic [31:0] d;
	int err_total = 0;
	int checked = 0;

	// ************************************************************
	// clocks and pin resolution
	// ************************************************************
	always #12.5 mclk = ~mclk;
	// a released tdo line shows the inverse of its current output level
	assign drv = h_sel_n ? ext_lvl
		: {h_trst_n, ~gpio_out.level[3], h_tdi, h_tms, h_tck};
	assign pad = (gpio_out.oe & gpio_out.level) | (~gpio_out.oe & drv);

	bsp_pin_share_tap #(.BSR_LEN(BSR), .IDCODE_VALUE(ID_WORD)) i_dut (
		.mclk_i(mclk),
		.rst_n_i(rst_n & h_mr_n),
		.tck_i(pad[0]),
		.test_access_select_n_i(h_sel_n),
		.gpio_pad_i(pad),
		.gpio_pad_o(gpio_out),
		.core_gpio_i(core_gpio),
		.gpio_din_o(gpio_din),
		.core_halt_o(halt),
		.bs_pad_in_i(bs_in),
		.core_pad_out_i(core_out),
		.core_pad_oe_i(core_oe),
		.bs_pad_out_o(bs_out),
		.bs_pad_oe_o(bs_oe)
	);

	bsp_jtag_host i_host (
		.mclk_i(mclk),
		.tdo_i(pad[3]),
		.tck_o(h_tck),
		.tms_o(h_tms),
		.tdi_o(h_tdi),
		.trst_n_o(h_trst_n),
		.sel_n_o(h_sel_n),
		.mr_n_o(h_mr_n)
	);

	// ************************************************************
	// helpers
	// ************************************************************
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			$display("unexpected %s expected %h seen %h", what, exp, got);
			err_total++;
		end
	endtask : chk

	task automatic ticks(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : ticks

	task automatic load_ir(input logic [3:0] op);
		i_host.enter_shift(1'b1);
		i_host.shift_out(4, {28'h0, op}, d);
		chk("ir capture", bsp_pkg::BSP_IR_CAPTURE, d);
	endtask : load_ir

	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_normal();
		@(posedge mclk);
		core_gpio <= {5'h16, 5'h0c};
		ext_lvl <= 5'h09;
		ticks(8);
		chk("pad drive", {5'h16, 5'h0c}, gpio_out);
		// core drives pins 2 and 3, the board drives the rest
		chk("pad in", 5'h05, gpio_din);
		chk("halt", 1'b0, halt);
		$display("test normal done");
	endtask : t_normal

	task automatic t_enter();
		i_host.enter_test();
		ticks(3);
		chk("halt early", 1'b0, halt);
		ticks(3);
		chk("halt", 1'b1, halt);
		chk("pad drive test", 5'h00, gpio_out.oe);
		$display("test enter done");
	endtask : t_enter

	// identification word straight after reset, tdo enabled only in shift
	task automatic t_idcode();
		i_host.reset_tap();
		i_host.enter_shift(1'b0);
		#1; // enable flop moves on the falling edge that just happened
		chk("tdo enable", 5'h08, gpio_out.oe);
		i_host.shift_out(32, 32'h0, d);
		chk("id word", ID_WORD, d);
		chk("tdo idle", 5'h00, gpio_out.oe);
		$display("test idcode done");
	endtask : t_idcode

	// bypass and an unknown opcode both give one bit of delay
	task automatic t_bypass();
		logic [3:0] ops [2] = '{bsp_pkg::BSP_OP_BYPASS, 4'h7};
		foreach (ops[k]) begin
			load_ir(ops[k]);
			i_host.enter_shift(1'b0);
			i_host.shift_out(9, 32'h1a5, d);
			chk("bypass", (32'h1a5 << 1) & 32'h1ff, d);
		end
		$display("test bypass done");
	endtask : t_bypass

	task automatic t_boundary();
		@(posedge mclk);
		bs_in <= 8'ha5;
		core_out <= 8'h5a;
		core_oe <= 8'hc3;
		load_ir(bsp_pkg::BSP_OP_SAMPLE);
		chk("pass out", 8'h5a, bs_out);
		chk("pass oe", 8'hc3, bs_oe);
		i_host.enter_shift(1'b0);
		i_host.shift_out(8, 32'h3c, d);
		chk("sample", 8'ha5, d);
		load_ir(bsp_pkg::BSP_OP_EXTEST);
		chk("extest out", 8'h3c, bs_out);
		chk("extest oe", 8'hff, bs_oe);
		load_ir(bsp_pkg::BSP_OP_HIGHZ);
		chk("highz oe", 8'h00, bs_oe);
		chk("highz out", 8'h5a, bs_out);
		@(posedge mclk);
		bs_in <= 8'h69;
		load_ir(bsp_pkg::BSP_OP_PRELOAD);
		i_host.enter_shift(1'b0);
		i_host.shift_out(8, 32'hc3, d);
		chk("preload", 8'h69, d);
		load_ir(bsp_pkg::BSP_OP_CLAMP);
		chk("clamp out", 8'hc3, bs_out);
		chk("clamp oe", 8'hff, bs_oe);
		$display("test boundary done");
	endtask : t_boundary

	// test reset mid-shift drops tdo at once and restores the id word
	task automatic t_trst();
		logic b;
		load_ir(bsp_pkg::BSP_OP_BYPASS);
		i_host.enter_shift(1'b0);
		i_host.set_trst(1'b0);
		#5;
		chk("tdo after trst", 5'h00, gpio_out.oe);
		i_host.set_trst(1'b1);
		i_host.clk(1'b0, 1'b0, b);
		i_host.enter_shift(1'b0);
		i_host.shift_out(32, 32'h0, d);
		chk("id after trst", ID_WORD, d);
		$display("test trst done");
	endtask : t_trst

	task automatic t_leave();
		i_host.leave_test();
		core_gpio <= {5'h0b, 5'h03};
		ext_lvl <= 5'h1c;
		ticks(8);
		chk("halt after", 1'b0, halt);
		chk("pad drive after", {5'h0b, 5'h03}, gpio_out);
		chk("pad in after", 5'h1f, gpio_din);
		$display("test leave done");
	endtask : t_leave

	// ************************************************************
	// run control
	// ************************************************************
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict

	initial begin
		ext_lvl <= 5'h12;
		bs_in <= 8'h0f;
		core_out <= 8'hf0;
		core_oe <= 8'h3c;
		core_gpio <= {5'h05, 5'h1f};
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		ticks(2);
		t_normal();
		t_enter();
		t_idcode();
		t_bypass();
		t_boundary();
		t_trst();
		t_leave();
		give_verdict();
	end

	// the whole sequence needs well under 20 us
	initial begin
		#200000;
		err_total++;
		$display("watchdog expired");
		give_verdict();
	end
endmodule : bsp_pin_share_tap_bench

`default_nettype wire
